/* shared/dies_cfg_if.sv */
// Configuration fields and held state passed between the block's modules
`timescale 1ns/10ps
interface dies_cfg_if;
  logic enabled;
  logic [4:0] user_field;
  logic byte_sel;
  logic la_sel;
  logic [7:0] logical_address;
  logic [15:0] vector;
  modport regs (output enabled, output user_field);
  modport vec (input user_field, input byte_sel, input la_sel, input logical_address,
    output vector);
  modport top (input enabled, input user_field, input vector, output byte_sel, output la_sel,
    output logical_address);
endinterface

/* shared/dies_defs.svh */
// Offsets, field positions and constants of the DMA interrupt block
`ifndef DIES_DEFS_SVH
`define DIES_DEFS_SVH
`define DIES_ENABLE_OFS 8'h12
`define DIES_VECTOR_OFS 8'h20
`define DIES_QUAL_BIT 11
`define DIES_SETCLR_BIT 8
`define DIES_USER_HI 7
`define DIES_USER_LO 3
`define DIES_USER_RST 5'h00
`define DIES_LOW_IACK 3'h3
`define DIES_LOW_READ 3'h0
`define DIES_EN_RST 1'b0
`define DIES_IRQ_IDLE 7'h7f
`define DIES_LVL_NONE 3'h0
`endif

/* shared/dies_pkg.sv */
// Types of the DMA interrupt block
package dies_pkg;
  typedef enum logic [1:0] {
    DIES_IDLE,
    DIES_REQ,
    DIES_DONE
  } dies_state_t;
endpackage

/* src/dies_regs.sv */
// Enable and user vector field storage, cleared by hard reset only; soft reset leaves them alone
`timescale 1ns/10ps
`include "dies_defs.svh"
module dies_regs (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic wr_vec,
  input wire logic [1:0] be,
  input wire logic [15:0] wdata,
  dies_cfg_if.regs cfg
);
  logic en_q, en_d;
  logic [4:0] user_q, user_d;
  always_comb begin
    en_d = en_q;
    user_d = user_q;
    // Qualifier must be one, else the write leaves the enable alone
    if (wr_en && be[1] && wdata[`DIES_QUAL_BIT]) begin
      en_d = wdata[`DIES_SETCLR_BIT];
    end
    if (wr_vec && be[0]) begin
      user_d = wdata[`DIES_USER_HI:`DIES_USER_LO];
    end
  end
  // Only the hard reset reaches these; soft reset is not wired in on purpose
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      en_q <= `DIES_EN_RST;
      user_q <= `DIES_USER_RST;
    end else begin
      en_q <= en_d;
      user_q <= user_d;
    end
  end
  assign cfg.enabled = en_q;
  assign cfg.user_field = user_q;
endmodule // dies_regs

/* src/dies_top.sv */
// DMA interrupt enable, Status/ID and VMEbus request/acknowledge logic
`timescale 1ns/10ps
`include "dies_defs.svh"
module dies_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  input wire logic dma_condition,
  input wire logic [2:0] irq_level_select,
  input wire logic byte_vector_select,
  input wire logic logical_address_vector_select,
  input wire logic [7:0] logical_address,
  input wire logic iack_pin,
  input wire logic [2:0] iack_level_pin,
  input wire logic iack_byte_pin,
  output logic [7:1] irq_n,
  output logic [15:0] iack_vector,
  output logic iack_dtack,
  output logic irq_condition_flag
);
  dies_cfg_if cfg ();

  // Register port decode
  logic sel_en;
  logic sel_vec;
  logic wr_en_hit;
  logic wr_vec_hit;
  logic rd_en_hit;
  logic rd_vec_hit;

  // Acknowledge pin synchronisers and edge detector
  logic iack_s1_q;
  logic iack_s1_d;
  logic iack_s2_q;
  logic iack_s2_d;
  logic iack_s3_q;
  logic iack_s3_d;
  logic iack_prev_q;
  logic iack_prev_d;
  logic [2:0] lvl_s1_q;
  logic [2:0] lvl_s1_d;
  logic [2:0] lvl_s2_q;
  logic [2:0] lvl_s2_d;
  logic byte_s1_q;
  logic byte_s1_d;
  logic byte_s2_q;
  logic byte_s2_d;
  logic iack_rise;
  logic lvl_hit;
  logic size_ok;
  logic match;

  // Register read port
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic ack_q;
  logic ack_d;

  // Request and acknowledge state
  dies_pkg::dies_state_t st_q;
  dies_pkg::dies_state_t st_d;
  logic [7:1] irq_n_q;
  logic [7:1] irq_n_d;
  logic [15:0] ivec_q;
  logic [15:0] ivec_d;
  logic dtack_q;
  logic dtack_d;
  logic arm_ok;

  // Condition flag
  logic flag_q;
  logic flag_d;

  // Exact offset match; neighbouring bytes of the slave space are not ours
  function automatic logic dies_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // Level zero names no request line, so it must never assert or answer
  function automatic logic dies_lvl_ok(input logic [2:0] lvl);
    return lvl != `DIES_LVL_NONE;
  endfunction

  // Active-low line pattern with only the selected level pulled down
  function automatic logic [7:1] dies_line(input logic [2:0] lvl);
    logic [7:1] m;
    m = `DIES_IRQ_IDLE;
    for (int i = 1; i < 8; i++) begin
      if (lvl == 3'(i)) begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction

  assign cfg.byte_sel = byte_vector_select;
  assign cfg.la_sel = logical_address_vector_select;
  assign cfg.logical_address = logical_address;

  assign sel_en = dies_hit(reg_addr, `DIES_ENABLE_OFS);
  assign sel_vec = dies_hit(reg_addr, `DIES_VECTOR_OFS);
  assign wr_en_hit = reg_wr && sel_en;
  assign wr_vec_hit = reg_wr && sel_vec;
  assign rd_en_hit = reg_rd && sel_en;
  assign rd_vec_hit = reg_rd && sel_vec;

  dies_regs u_regs (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(wr_en_hit),
    .wr_vec(wr_vec_hit),
    .be(reg_be),
    .wdata(reg_wdata),
    .cfg(cfg)
  );

  dies_vec u_vec (
    .cfg(cfg)
  );

  // Acknowledge pins come from the backplane, so each passes two flops.
  // The strobe gets two more stages, so the level and size lines that it
  // qualifies have been stable for a cycle when its rise is seen.
  always_comb begin
    iack_s1_d = iack_pin;
    iack_s2_d = iack_s1_q;
    iack_s3_d = iack_s2_q;
    iack_prev_d = iack_s3_q;
    lvl_s1_d = iack_level_pin;
    lvl_s2_d = lvl_s1_q;
    byte_s1_d = iack_byte_pin;
    byte_s2_d = byte_s1_q;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      iack_s1_q <= 1'b0;
      iack_s2_q <= 1'b0;
      iack_s3_q <= 1'b0;
      iack_prev_q <= 1'b0;
      lvl_s1_q <= 3'h0;
      lvl_s2_q <= 3'h0;
      byte_s1_q <= 1'b0;
      byte_s2_q <= 1'b0;
    end else begin
      iack_s1_q <= iack_s1_d;
      iack_s2_q <= iack_s2_d;
      iack_s3_q <= iack_s3_d;
      iack_prev_q <= iack_prev_d;
      lvl_s1_q <= lvl_s1_d;
      lvl_s2_q <= lvl_s2_d;
      byte_s1_q <= byte_s1_d;
      byte_s2_q <= byte_s2_d;
    end
  end

  // Prev resets to the idle level of the pin, so reset makes no false edge
  assign iack_rise = iack_s3_q && !iack_prev_q;
  assign lvl_hit = (lvl_s2_q == irq_level_select) && dies_lvl_ok(irq_level_select);
  // Word vector mode ignores byte-wide acknowledge cycles
  assign size_ok = byte_vector_select || !byte_s2_q;
  assign match = iack_rise && lvl_hit && size_ok;

  // Register read path; reserved bits read as zero
  always_comb begin
    rdata_d = 16'h0000;
    ack_d = reg_wr || reg_rd;
    if (rd_en_hit) begin
      rdata_d[`DIES_QUAL_BIT] = cfg.enabled;
    end else if (rd_vec_hit) begin
      rdata_d[`DIES_USER_HI:0] = {cfg.user_field, `DIES_LOW_READ};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // Request state: flag is sticky and held by the DMA condition, which
  // software clears through the channel controls before re-enabling
  assign arm_ok = cfg.enabled && dies_lvl_ok(irq_level_select);

  always_comb begin
    st_d = st_q;
    irq_n_d = `DIES_IRQ_IDLE;
    ivec_d = ivec_q;
    dtack_d = 1'b0;
    case (st_q)
      dies_pkg::DIES_IDLE: begin
        if (arm_ok && dma_condition) begin
          st_d = dies_pkg::DIES_REQ;
        end
      end
      dies_pkg::DIES_REQ: begin
        if (!arm_ok) begin
          // Disabling mid-request drops the line at once
          st_d = dies_pkg::DIES_IDLE;
        end else if (match) begin
          // Line is released in the cycle that the answer is given
          ivec_d = cfg.vector;
          dtack_d = 1'b1;
          st_d = dies_pkg::DIES_DONE;
        end else begin
          irq_n_d = dies_line(irq_level_select);
        end
      end
      dies_pkg::DIES_DONE: begin
        // Stays released until disabled, so one request per arming
        if (!cfg.enabled) begin
          st_d = dies_pkg::DIES_IDLE;
        end
      end
      default: begin
        st_d = dies_pkg::DIES_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= dies_pkg::DIES_IDLE;
      irq_n_q <= `DIES_IRQ_IDLE;
      ivec_q <= 16'h0000;
      dtack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      irq_n_q <= irq_n_d;
      ivec_q <= ivec_d;
      dtack_q <= dtack_d;
    end
  end

  // Flag mirrors the latched condition; acknowledge never clears it.
  // The latch lives in the DMA logic, so there is no second copy to
  // fall out of step with the channel's clear controls.
  always_comb begin
    flag_d = dma_condition;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Every output comes straight from a flop
  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign irq_n = irq_n_q;
  assign iack_vector = ivec_q;
  assign iack_dtack = dtack_q;
  assign irq_condition_flag = flag_q;
endmodule // dies_top

/* src/dies_vec.sv */
// Status/ID vector composition for acknowledge cycles
`timescale 1ns/10ps
`include "dies_defs.svh"
module dies_vec (
  dies_cfg_if.vec cfg
);
  logic [15:0] v;
  always_comb begin
    if (cfg.byte_sel && cfg.la_sel) begin
      v = {8'h00, cfg.logical_address};
    end else if (cfg.byte_sel) begin
      v = {8'h00, cfg.user_field, `DIES_LOW_IACK};
    end else begin
      v = {cfg.user_field, `DIES_LOW_IACK, cfg.logical_address};
    end
  end
  assign cfg.vector = v;
endmodule // dies_vec

/* tb/dies_handler.sv */
// Interrupt handler model that acknowledges the block's request line
`timescale 1ns/10ps
module dies_handler (
  input wire logic clock,
  input wire logic [7:1] irq_n,
  input wire logic iack_dtack,
  input wire logic byte_cyc,
  input wire logic wrong_lvl,
  output logic iack_pin,
  output logic [2:0] iack_level_pin,
  output logic iack_byte_pin
);
  logic [4:0] cnt_q;
  logic [2:0] lvl;
  initial begin
    iack_pin = 1'b0;
    iack_level_pin = 3'h0;
    iack_byte_pin = 1'b0;
    cnt_q = 5'h00;
  end
  always_comb begin
    lvl = 3'h0;
    for (int i = 1; i < 8; i++) if (!irq_n[i]) lvl = 3'(i);
  end
  always @(posedge clock) begin
    if (!iack_pin) begin
      // Idle lines carry no stable value
      iack_level_pin <= ~iack_level_pin;
      iack_byte_pin <= ~iack_byte_pin;
      if (irq_n != 7'h7f) begin
        iack_pin <= 1'b1;
        iack_level_pin <= wrong_lvl ? lvl ^ 3'h1 : lvl;
        iack_byte_pin <= byte_cyc;
        cnt_q <= 5'h00;
      end
    end else begin
      cnt_q <= cnt_q + 5'h01;
      // Give up on an unanswered cycle, as a bus timer would
      if (iack_dtack || cnt_q == 5'h14) iack_pin <= 1'b0;
    end
  end
endmodule // dies_handler

/* tb/dies_top_asserts.sv */
// Port assertions of the DMA interrupt block
`timescale 1ns/10ps
module dies_top_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic dma_condition,
  input wire logic [2:0] irq_level_select,
  input wire logic byte_vector_select,
  input wire logic [7:0] logical_address,
  input wire logic [7:1] irq_n,
  input wire logic [15:0] iack_vector,
  input wire logic iack_dtack,
  input wire logic irq_condition_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_ACK: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
  AST_NOACK: assert property (!(reg_wr || reg_rd) |=> !reg_ack) else $error("stray ack");
  AST_SETCLR: assert property (reg_ack && $past(reg_addr) == 8'h12 |-> !reg_rdata[8])
    else $error("set bit read one");
  AST_RDLOW: assert property (reg_ack && $past(reg_addr) == 8'h20 |-> reg_rdata[2:0] == 3'h0)
    else $error("low bits not zero");
  AST_PULSE: assert property (iack_dtack |=> !iack_dtack) else $error("long dtack");
  AST_REL: assert property (iack_dtack |-> irq_n == 7'h7f) else $error("line held");
  AST_LVL: assert property (irq_n != 7'h7f |-> ~{irq_n, 1'b1} == 8'h01 << irq_level_select)
    else $error("wrong line");
  AST_COND: assert property (irq_n != 7'h7f |-> $past(dma_condition, 2)) else $error("no cause");
  AST_WORD: assert property (iack_dtack && !byte_vector_select |->
    iack_vector[10:0] == {3'h3, logical_address}) else $error("bad word vector");
  AST_FLAG: assert property ($rose(dma_condition) |=> irq_condition_flag) else $error("flag");
endmodule // dies_top_asserts
bind dies_top dies_top_asserts dies_top_asserts_inst (.*);

/* tb/dies_top_bench.sv */
// Self-checking bench of the DMA interrupt block
`timescale 1ns/10ps
module dies_top_bench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, dma_condition = 1'b0;
  logic byte_vector_select = 1'b0, logical_address_vector_select = 1'b0;
  logic byte_cyc = 1'b0, wrong_lvl = 1'b0;
  logic [7:0] reg_addr = 8'h00, logical_address = 8'h00, la;
  logic [1:0] reg_be = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, iack_vector;
  logic [2:0] irq_level_select = 3'h1, iack_level_pin, lv;
  logic [7:1] irq_n;
  logic reg_ack, iack_dtack, irq_condition_flag, iack_pin, iack_byte_pin;
  logic [31:0] rq[$], vq[$], e;
  logic [4:0] u;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #2 clock = ~clock;
  dies_top dies_top_inst (.*);
  dies_handler dies_handler_inst (.*);
  task automatic chk(input string s, input logic [15:0] x, input logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Access: write flag, offset, lanes, data, read mask, expected masked read
  task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] b,
      input logic [15:0] d, input logic [15:0] m, input logic [15:0] x);
    rq.push_back({m, x});
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_be <= b;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (reg_ack === 1'b1) begin
      e = rq.size() ? rq.pop_front() : 32'hffffffff;
      chk("reg_rdata", e[15:0], reg_rdata & e[31:16]);
    end
    if (iack_dtack === 1'b1) begin
      e = vq.size() ? vq.pop_front() : 32'hffffffff;
      chk("iack_vector", e[15:0], iack_vector & e[31:16]);
    end
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h420cdd42));
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int k = 0; k < 2; k++) begin
      acc(0, 8'h12, 2'h3, 0, 16'h0900, 16'h0000);
      acc(0, 8'h20, 2'h3, 0, 16'h00ff, 16'h0000);
      acc(0, 8'h44, 2'h3, 0, 16'hffff, 16'h0000);
      u = 5'($urandom);
      acc(1, 8'h20, 2'h1, {8'h00, u, 3'h0}, 0, 0);
      acc(1, 8'h12, 2'h2, 16'h0900, 0, 0);
      soft_rst <= 1'b1;
      @(posedge clock);
      soft_rst <= 1'b0;
      acc(0, 8'h20, 2'h3, 0, 16'h00ff, {8'h00, u, 3'h0});
      acc(0, 8'h12, 2'h3, 0, 16'h0900, 16'h0800);
      sys_rst <= 1'b1;
      @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
    end
    acc(1, 8'h20, 2'h1, {8'h00, u, 3'h0}, 0, 0);
    for (int m = 0; m < 5; m++) begin
      lv = 3'($urandom_range(7, 1));
      la = 8'($urandom);
      irq_level_select <= lv;
      logical_address <= la;
      byte_vector_select <= m == 1 || m == 2;
      logical_address_vector_select <= m == 2;
      byte_cyc <= m >= 2;
      wrong_lvl <= m == 4;
      dma_condition <= 1'b1;
      if (m == 0) vq.push_back({16'hffff, u, 3'h3, la});
      if (m == 1) vq.push_back({16'h00ff, 8'h00, u, 3'h3});
      if (m == 2) vq.push_back({16'h00ff, 8'h00, la});
      @(posedge clock);
      acc(1, 8'h12, 2'h2, 16'h0900, 0, 0);
      repeat (40) @(posedge clock);
      chk("pending", 0, 16'(vq.size()));
      chk("irq_n", {9'h0, m < 3 ? 7'h7f : ~7'(8'h01 << (lv - 1))}, {9'h0, irq_n});
      chk("flag", 1, {15'h0, irq_condition_flag});
      acc(1, 8'h12, 2'h2, 16'h0800, 0, 0);
      repeat (2) @(posedge clock);
      dma_condition <= 1'b0;
      @(posedge clock);
    end
    summarize();
  end
endmodule // dies_top_bench
